// *** rtl/pid_process_regulator.sv ***
// Purpose: closed-loop process regulator over the speed command
// Assumes: analog samples and digital inputs synchronous to clk_i
// Notes:   registers on Avalon-MM, one wait state per access
`timescale 1ns/10ps
// Behaviour
// - enabled regulator drives speed to hold setpoint
// - feedback only from the analog feedback input
// - setpoint from keypad value or scaled pot
// - display feedback scaled by display factor
// - input coded 27 closed means manual
// - no input coded 27 means automatic
// - source other than 0 or 3 flags error
// - manual to auto copies feedback into keypad
// - action setting inverts error sign
// - feedback decoded per signal type
// - feedback low-pass, zero to ten seconds
// - keypad setpoint 0-100 %, kept with backup
module pid_process_regulator #(
  parameter int TICK_CYC = regulator_pkg::TICK_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [11:0] analog_feedback_input_i,
  input  wire logic [11:0] pot_input_i,
  input  wire logic [3:0]  di_i,
  input  wire logic        remote_sel_i,
  input  wire logic [15:0] manual_ref_i,
  input  wire logic [15:0] speed_ref_i,
  output logic      [15:0] freq_cmd_o,
  output logic      [15:0] process_variable_display_o,
  output logic      [7:0]  programming_error_code_o,
  output logic             manual_mode_o,
  output logic             irq_o
);
  function automatic logic [9:0] sat_pct(input logic [31:0] v);
    sat_pct = (v > regulator_pkg::PCT_MAX) ?
              regulator_pkg::PCT_MAX[9:0] : v[9:0];
  endfunction

  function automatic logic [31:0] pct_of_raw(input logic [11:0] raw,
                                              input logic [1:0]  sig);
    logic [31:0] r;
    r = {20'h0, raw};
    if (sig == regulator_pkg::SIG_MA420) begin
      if (r > regulator_pkg::ADC_4MA) begin
        pct_of_raw = ((r - regulator_pkg::ADC_4MA) *
                      regulator_pkg::SPAN_420) >> regulator_pkg::ADC_BITS;
      end else begin
        pct_of_raw = 32'h0;
      end
    end else begin
      pct_of_raw = (r * regulator_pkg::SPAN_FULL) >> regulator_pkg::ADC_BITS;
    end
  endfunction

  // gain is in percent, 100 = unity; /100 done by multiply and shift
  function automatic logic [31:0] gain_off(input logic [31:0] pct,
                                            input logic [15:0] gain,
                                            input logic [9:0]  off);
    logic [47:0] m;
    m = (({16'h0, pct} * {32'h0, gain}) * regulator_pkg::DIV100_MUL)
        >> regulator_pkg::DIV100_SH;
    gain_off = m[31:0] + {22'h0, off};
  endfunction

  function automatic logic src_ok(input logic [2:0] s);
    src_ok = (s == regulator_pkg::SRC_KEYPAD) ||
             (s == regulator_pkg::SRC_POT);
  endfunction

  function automatic logic [15:0] clamp_f(input logic signed [31:0] v,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
    if (v < $signed({16'h0, lo})) begin
      clamp_f = lo;
    end else if (v > $signed({16'h0, hi})) begin
      clamp_f = hi;
    end else begin
      clamp_f = v[15:0];
    end
  endfunction

  function automatic logic [3:0] shift_of(input logic [6:0] tau);
    logic [13:0] t;
    t = 14'(tau) * 14'(regulator_pkg::TICKS_TENTH);
    shift_of = 4'h0;
    for (int i = 1; i <= regulator_pkg::SHIFT_MAX; i++) begin
      if (t >= (14'h1 << i)) begin
        shift_of = 4'(i);
      end
    end
  endfunction

  logic        [15:0] tick_cnt_q;
  logic               tick_q;
  logic               wait_q;
  logic        [31:0] rdata_q;
  logic        [31:0] rdata_d;
  logic               acc;
  logic               wr_commit;
  logic        [5:0]  ctrl_q;
  logic        [2:0]  local_q;
  logic        [2:0]  remote_q;
  logic        [4:0]  difn_q [regulator_pkg::NDI];
  logic        [9:0]  keypad_q;
  logic        [15:0] fb_gain_q;
  logic        [9:0]  fb_off_q;
  logic        [15:0] pot_gain_q;
  logic        [9:0]  pot_off_q;
  logic        [15:0] kp_q;
  logic        [15:0] ki_q;
  logic        [15:0] kd_q;
  logic        [15:0] dscale_q;
  logic        [6:0]  filt_q;
  logic        [15:0] fmin_q;
  logic        [15:0] fmax_q;
  logic               manual_q;
  logic               err_q;
  logic        [7:0]  code_q;
  logic        [15:0] freq_q;
  logic        [15:0] disp_q;
  logic signed [31:0] integ_q;
  logic signed [31:0] eprev_q;
  logic [regulator_pkg::NIRQ-1:0] ist_q;
  logic [regulator_pkg::NIRQ-1:0] imask_q;
  logic [regulator_pkg::NIRQ-1:0] ev;
  logic               irq_q;
  logic               en;
  logic        [9:0]  fb_pct;
  logic        [9:0]  pot_sp;
  logic        [9:0]  pv;
  logic        [9:0]  sp;
  logic        [2:0]  src;
  logic               err_d;
  logic               manual_d;
  logic               bump;
  logic signed [31:0] e0;
  logic signed [31:0] e;
  logic signed [31:0] i_d;
  logic signed [31:0] sum;
  logic signed [31:0] out_raw;
  logic        [15:0] out_cl;
  logic        [47:0] disp_m;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_q <= 16'h0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 16'(TICK_CYC - 1)) begin
      tick_cnt_q <= 16'h0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h1;
      tick_q     <= 1'b0;
    end
  end

  // waitrequest idles high so each access gets exactly one wait cycle
  assign acc       = (avs_read_i | avs_write_i) & wait_q;
  assign wr_commit = avs_write_i & ~wait_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q <= ~acc;
      if (acc & avs_read_i) begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q     <= regulator_pkg::RST_CTRL;
      local_q    <= regulator_pkg::SRC_KEYPAD;
      remote_q   <= regulator_pkg::SRC_KEYPAD;
      difn_q     <= '{default: 5'h0};
      fb_gain_q  <= regulator_pkg::RST_FBGAIN;
      fb_off_q   <= 10'h0;
      pot_gain_q <= regulator_pkg::RST_POTGN;
      pot_off_q  <= 10'h0;
      kp_q       <= regulator_pkg::RST_KP;
      ki_q       <= regulator_pkg::RST_KI;
      kd_q       <= regulator_pkg::RST_KD;
      dscale_q   <= regulator_pkg::RST_DSCALE;
      filt_q     <= regulator_pkg::RST_FILT;
      fmin_q     <= regulator_pkg::RST_FMIN;
      fmax_q     <= regulator_pkg::RST_FMAX;
      imask_q    <= '0;
    end else if (wr_commit) begin
      unique case (avs_address_i)
        regulator_pkg::OFF_CTRL: ctrl_q <= avs_writedata_i[5:0];
        regulator_pkg::OFF_REFSRC: begin
          local_q  <= avs_writedata_i[2:0];
          remote_q <= avs_writedata_i[6:4];
        end
        regulator_pkg::OFF_DIFN: begin
          for (int k = 0; k < regulator_pkg::NDI; k++) begin
            difn_q[k] <= avs_writedata_i[8*k +: 5];
          end
        end
        regulator_pkg::OFF_FB: begin
          fb_gain_q <= avs_writedata_i[15:0];
          fb_off_q  <= avs_writedata_i[25:16];
        end
        regulator_pkg::OFF_POT: begin
          pot_gain_q <= avs_writedata_i[15:0];
          pot_off_q  <= avs_writedata_i[25:16];
        end
        regulator_pkg::OFF_KPKI: begin
          kp_q <= avs_writedata_i[15:0];
          ki_q <= avs_writedata_i[31:16];
        end
        regulator_pkg::OFF_KDDS: begin
          kd_q     <= avs_writedata_i[15:0];
          dscale_q <= avs_writedata_i[31:16];
        end
        regulator_pkg::OFF_FILT: begin
          filt_q <= (avs_writedata_i[6:0] > regulator_pkg::FILT_MAX) ?
                    regulator_pkg::FILT_MAX : avs_writedata_i[6:0];
        end
        regulator_pkg::OFF_LIM: begin
          fmin_q <= avs_writedata_i[15:0];
          fmax_q <= avs_writedata_i[31:16];
        end
        regulator_pkg::OFF_IMSK: begin
          imask_q <= avs_writedata_i[regulator_pkg::NIRQ-1:0];
        end
        default: ;
      endcase
    end
  end

  assign en = ctrl_q[regulator_pkg::CTL_EN];
  // the setpoint is taken as percent; unit conversion is the operator's
  assign fb_pct = sat_pct(gain_off(pct_of_raw(analog_feedback_input_i,
                  ctrl_q[regulator_pkg::CTL_SIG +: 2]),
                  fb_gain_q, fb_off_q));
  assign pot_sp = sat_pct(gain_off(pct_of_raw(pot_input_i,
                  regulator_pkg::SIG_V10), pot_gain_q, pot_off_q));
  assign src = remote_sel_i ? remote_q : local_q;
  assign sp  = (src == regulator_pkg::SRC_POT) ? pot_sp : keypad_q;
  assign err_d = en && (!src_ok(local_q) || !src_ok(remote_q));

  always_comb begin
    manual_d = 1'b0;
    for (int k = 0; k < regulator_pkg::NDI; k++) begin
      if (di_i[k] && difn_q[k] == regulator_pkg::FN_MANUAL) begin
        manual_d = 1'b1;
      end
    end
  end

  pv_filter u_filter (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (tick_q),
    .shift_i (shift_of(filt_q)),
    .x_i     (fb_pct),
    .y_o     (pv)
  );

  assign bump = en && manual_q && !manual_d &&
                !ctrl_q[regulator_pkg::CTL_TRK];

  // hardware copy outranks a software write in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      keypad_q <= 10'h0;
    end else if (bump) begin
      keypad_q <= pv;
    end else if (wr_commit && avs_address_i == regulator_pkg::OFF_KEYPAD) begin
      keypad_q <= sat_pct(avs_writedata_i);
    end else if (!en && !ctrl_q[regulator_pkg::CTL_BKP]) begin
      keypad_q <= 10'h0;
    end
  end

  assign e0 = $signed({22'h0, sp}) - $signed({22'h0, pv});
  assign e  = ctrl_q[regulator_pkg::CTL_REV] ? -e0 : e0;
  always_comb begin
    i_d = integ_q + $signed({16'h0, ki_q}) * e;
    if (i_d > regulator_pkg::INTEG_LIM) begin
      i_d = regulator_pkg::INTEG_LIM;
    end else if (i_d < -regulator_pkg::INTEG_LIM) begin
      i_d = -regulator_pkg::INTEG_LIM;
    end
  end
  assign sum = $signed({16'h0, kp_q}) * e + i_d +
               $signed({16'h0, kd_q}) * (e - eprev_q);
  assign out_raw = sum >>> regulator_pkg::PID_SH;
  assign out_cl  = clamp_f(out_raw, fmin_q, fmax_q);

  // preloading the integrator keeps the output continuous on mode change
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      integ_q <= 32'sh0;
      eprev_q <= 32'sh0;
    end else if (!en || manual_q || err_q) begin
      integ_q <= $signed({16'h0, manual_ref_i}) <<< regulator_pkg::PID_SH;
      eprev_q <= e;
    end else if (tick_q) begin
      integ_q <= i_d;
      eprev_q <= e;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      freq_q <= 16'h0;
    end else if (!en || err_q) begin
      freq_q <= speed_ref_i;
    end else if (manual_q) begin
      freq_q <= clamp_f($signed({16'h0, manual_ref_i}),
                        fmin_q, fmax_q);
    end else if (tick_q) begin
      freq_q <= out_cl;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      manual_q <= 1'b0;
      err_q    <= 1'b0;
      code_q   <= 8'h0;
    end else begin
      manual_q <= en && manual_d;
      err_q    <= err_d;
      code_q   <= err_d ? regulator_pkg::ERR_CODE : 8'h0;
    end
  end

  assign disp_m = ({38'h0, pv} * {32'h0, dscale_q} * regulator_pkg::DISP_MUL)
                  >> regulator_pkg::DISP_SH;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      disp_q <= 16'h0;
    end else begin
      disp_q <= disp_m[15:0];
    end
  end

  always_comb begin
    ev                          = '0;
    ev[regulator_pkg::IRQ_ERR]  = err_d && !err_q;
    ev[regulator_pkg::IRQ_MODE] = (en && manual_d) != manual_q;
    ev[regulator_pkg::IRQ_LIM]  = tick_q && en && !manual_q && !err_q &&
                                  (out_raw != $signed({16'h0, out_cl}));
  end

  // a new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ist_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (wr_commit && avs_address_i == regulator_pkg::OFF_IST) begin
        ist_q <= (ist_q & ~avs_writedata_i[regulator_pkg::NIRQ-1:0]) | ev;
      end else begin
        ist_q <= ist_q | ev;
      end
      irq_q <= |(ist_q & imask_q);
    end
  end

  always_comb begin
    rdata_d = 32'h0;
    unique case (avs_address_i)
      regulator_pkg::OFF_CTRL:   rdata_d = {26'h0, ctrl_q};
      regulator_pkg::OFF_REFSRC: rdata_d = {25'h0, remote_q, 1'b0, local_q};
      regulator_pkg::OFF_DIFN:   rdata_d = {3'h0, difn_q[3], 3'h0, difn_q[2],
                                            3'h0, difn_q[1], 3'h0, difn_q[0]};
      regulator_pkg::OFF_KEYPAD: rdata_d = {22'h0, keypad_q};
      regulator_pkg::OFF_FB:     rdata_d = {6'h0, fb_off_q, fb_gain_q};
      regulator_pkg::OFF_POT:    rdata_d = {6'h0, pot_off_q, pot_gain_q};
      regulator_pkg::OFF_KPKI:   rdata_d = {ki_q, kp_q};
      regulator_pkg::OFF_KDDS:   rdata_d = {dscale_q, kd_q};
      regulator_pkg::OFF_FILT:   rdata_d = {25'h0, filt_q};
      regulator_pkg::OFF_LIM:    rdata_d = {fmax_q, fmin_q};
      regulator_pkg::OFF_STAT:   rdata_d = {14'h0, err_q, manual_q,
                                            6'h0, pv};
      regulator_pkg::OFF_DISP:   rdata_d = {16'h0, disp_q};
      regulator_pkg::OFF_IST:    rdata_d = {29'h0, ist_q};
      regulator_pkg::OFF_IMSK:   rdata_d = {29'h0, imask_q};
      default:                   rdata_d = 32'h0;
    endcase
  end

  assign avs_readdata_o             = rdata_q;
  assign avs_waitrequest_o          = wait_q;
  assign freq_cmd_o                 = freq_q;
  assign process_variable_display_o = disp_q;
  assign programming_error_code_o   = code_q;
  assign manual_mode_o              = manual_q;
  assign irq_o                      = irq_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_disabled_pass;
    !en |=> (freq_cmd_o == $past(speed_ref_i));
  endproperty
  a_disabled_pass: assert property (p_disabled_pass)
    else $error("disabled regulator did not pass speed reference");

  property p_err_code;
    err_d |=> (programming_error_code_o == regulator_pkg::ERR_CODE) && err_q;
  endproperty
  a_err_code: assert property (p_err_code)
    else $error("bad reference source gave no error code");

  property p_no_manual_fn;
    (manual_d == 1'b0) |=> !manual_mode_o;
  endproperty
  a_no_manual_fn: assert property (p_no_manual_fn)
    else $error("manual mode without a closed manual input");

  property p_manual_out;
    (en && manual_q && !err_q && fmin_q <= fmax_q) |=>
      (freq_cmd_o == clamp_f($signed({16'h0, $past(manual_ref_i)}),
                             $past(fmin_q), $past(fmax_q)));
  endproperty
  a_manual_out: assert property (p_manual_out)
    else $error("manual mode did not follow frequency reference");

  property p_bump;
    bump |=> (keypad_q == $past(pv));
  endproperty
  a_bump: assert property (p_bump)
    else $error("feedback not copied into keypad setpoint");

  property p_limits;
    (tick_q && en && !manual_q && !err_q && fmin_q <= fmax_q) |=>
      (freq_cmd_o >= $past(fmin_q)) && (freq_cmd_o <= $past(fmax_q));
  endproperty
  a_limits: assert property (p_limits)
    else $error("regulator output outside speed limits");

  property p_backup;
    (ctrl_q[regulator_pkg::CTL_BKP] && !bump && !wr_commit) |=>
      $stable(keypad_q);
  endproperty
  a_backup: assert property (p_backup)
    else $error("keypad setpoint lost with backup active");

  property p_keypad_range;
    keypad_q <= regulator_pkg::PCT_MAX[9:0];
  endproperty
  a_keypad_range: assert property (p_keypad_range)
    else $error("keypad setpoint above full scale");

  // reverse action with setpoint above feedback must never wind up
  property p_reverse;
    (tick_q && en && !manual_q && !err_q &&
     ctrl_q[regulator_pkg::CTL_REV] && sp > pv) |=>
      (integ_q <= $past(integ_q));
  endproperty
  a_reverse: assert property (p_reverse)
    else $error("reverse action did not invert error");
endmodule // pid_process_regulator

// *** rtl/pv_filter.sv ***
// Purpose: first-order low-pass on the process variable
// Assumes: tick_i is a one-cycle pulse at the sample rate
// Notes:   shift 0 passes the input straight through
`timescale 1ns/10ps
module pv_filter (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic [3:0] shift_i,
  input  wire logic [9:0] x_i,
  output logic      [9:0] y_o
);
  logic        [22:0] acc_q;
  logic signed [23:0] diff;
  logic signed [23:0] nxt;

  // 13 fraction bits keep slow settings from stalling on truncation
  assign diff = $signed({1'b0, x_i, 13'h0}) - $signed({1'b0, acc_q});
  assign nxt  = $signed({1'b0, acc_q}) + (diff >>> shift_i);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_q <= 23'h0;
    end else if (tick_i) begin
      acc_q <= nxt[22:0];
    end
  end

  assign y_o = acc_q[22:13];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_filter_pass;
    (tick_i && shift_i == 4'h0) |=> (y_o == $past(x_i));
  endproperty
  a_filter_pass: assert property (p_filter_pass)
    else $error("zero time constant did not pass feedback");

  property p_filter_hold;
    !tick_i |=> $stable(y_o);
  endproperty
  a_filter_hold: assert property (p_filter_hold)
    else $error("filter moved without a sample tick");
endmodule // pv_filter

// *** rtl/regulator_pkg.sv ***
// Purpose: shared constants for the process regulator
// Assumes: 40 MHz control clock, 12-bit analog samples
// Notes:   percent values are in 0.1 % steps, 1000 = 100.0 %
package regulator_pkg;
  localparam int          AW         = 6;
  localparam int          DW         = 32;
  localparam logic [5:0]  OFF_CTRL   = 6'h00;
  localparam logic [5:0]  OFF_REFSRC = 6'h04;
  localparam logic [5:0]  OFF_DIFN   = 6'h08;
  localparam logic [5:0]  OFF_KEYPAD = 6'h0C;
  localparam logic [5:0]  OFF_FB     = 6'h10;
  localparam logic [5:0]  OFF_POT    = 6'h14;
  localparam logic [5:0]  OFF_KPKI   = 6'h18;
  localparam logic [5:0]  OFF_KDDS   = 6'h1C;
  localparam logic [5:0]  OFF_FILT   = 6'h20;
  localparam logic [5:0]  OFF_LIM    = 6'h24;
  localparam logic [5:0]  OFF_STAT   = 6'h28;
  localparam logic [5:0]  OFF_DISP   = 6'h2C;
  localparam logic [5:0]  OFF_IST    = 6'h30;
  localparam logic [5:0]  OFF_IMSK   = 6'h34;
  localparam int          CTL_EN     = 0;
  localparam int          CTL_REV    = 1;
  localparam int          CTL_TRK    = 2;
  localparam int          CTL_BKP    = 3;
  localparam int          CTL_SIG    = 4;
  localparam logic [1:0]  SIG_V10    = 2'h0;
  localparam logic [1:0]  SIG_MA420  = 2'h1;
  localparam logic [1:0]  SIG_MA020  = 2'h2;
  localparam logic [2:0]  SRC_KEYPAD = 3'h0;
  localparam logic [2:0]  SRC_POT    = 3'h3;
  localparam logic [4:0]  FN_MANUAL  = 5'h1B;
  localparam logic [7:0]  ERR_CODE   = 8'h18;
  localparam int          NDI        = 4;
  localparam int          ADC_BITS   = 12;
  localparam logic [31:0] PCT_MAX    = 32'h0000_03E8;
  localparam logic [31:0] ADC_4MA    = 32'h0000_0333;
  localparam logic [31:0] SPAN_420   = 32'h0000_04E2;
  localparam logic [31:0] SPAN_FULL  = 32'h0000_03E8;
  localparam logic [47:0] DIV100_MUL = 48'h0000_0000_051F;
  localparam int          DIV100_SH  = 17;
  localparam logic [47:0] DISP_MUL   = 48'h0000_0000_0419;
  localparam int          DISP_SH    = 20;
  localparam int          PID_SH     = 10;
  localparam logic signed [31:0] INTEG_LIM = 32'sh1000_0000;
  localparam int          CLK_HZ     = 40_000_000;
  localparam int          TICK_US    = 1000;
  localparam int          TICK_CYC   = CLK_HZ / 1_000_000 * TICK_US;
  localparam int          TENTH_US   = 100_000;
  localparam int          TICKS_TENTH = TENTH_US / TICK_US;
  localparam int          SHIFT_MAX  = 13;
  localparam logic [5:0]  RST_CTRL   = 6'h10;
  localparam logic [15:0] RST_FBGAIN = 16'h0064;
  localparam logic [15:0] RST_POTGN  = 16'h0064;
  localparam logic [15:0] RST_KP     = 16'h03E8;
  localparam logic [15:0] RST_KI     = 16'h03E8;
  localparam logic [15:0] RST_KD     = 16'h0000;
  localparam logic [15:0] RST_DSCALE = 16'h03E8;
  localparam logic [6:0]  RST_FILT   = 7'h01;
  localparam logic [6:0]  FILT_MAX   = 7'h64;
  localparam logic [15:0] RST_FMIN   = 16'h0000;
  localparam logic [15:0] RST_FMAX   = 16'h0258;
  localparam int          IRQ_ERR    = 0;
  localparam int          IRQ_MODE   = 1;
  localparam int          IRQ_LIM    = 2;
  localparam int          NIRQ       = 3;
endpackage

// *** tb/plant_model.sv ***
// Purpose: transducer and motor model for the regulator bench
// Assumes: process reading follows the speed command
// Notes:   zero_i models a sensor that reads zero
`timescale 1ns/10ps
module plant_model (
  input  wire logic        clk_i,
  input  wire logic        zero_i,
  input  wire logic [15:0] freq_i,
  output logic      [11:0] fb_o
);
  // direct plant kept under full scale, so a 100 % setpoint is never met
  always_ff @(posedge clk_i) begin
    fb_o <= zero_i ? 12'h000 : {freq_i[10:0], 1'b0};
  end
endmodule // plant_model

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the process regulator
// Assumes: one wait state per register access
// Notes:   short tick keeps the closed-loop runs brief
`timescale 1ns/10ps
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [5:0]  adr   = 6'h00;
  logic        rd    = 1'b0;
  logic        wr    = 1'b0;
  logic [31:0] wdat  = 32'h0;
  logic [11:0] pot   = 12'h000;
  logic [3:0]  di    = 4'h0;
  logic        rsel  = 1'b0;
  logic        zero  = 1'b0;
  logic [15:0] mref  = 16'h0000;
  logic [15:0] sref  = 16'h0000;
  logic [31:0] rdat;
  logic        wt_o;
  logic [11:0] fb;
  logic [15:0] freq;
  logic [15:0] disp;
  logic [7:0]  code;
  logic        man;
  logic        irq;
  logic [63:0] notes[$];
  logic [63:0] n;
  int          errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  pid_process_regulator #(.TICK_CYC(20)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt_o),
    .analog_feedback_input_i(fb), .pot_input_i(pot), .di_i(di),
    .remote_sel_i(rsel), .manual_ref_i(mref), .speed_ref_i(sref),
    .freq_cmd_o(freq), .process_variable_display_o(disp),
    .programming_error_code_o(code), .manual_mode_o(man), .irq_o(irq));
  plant_model plant (.clk_i(clk_i), .zero_i(zero), .freq_i(freq),
    .fb_o(fb));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic summarize();
    if (errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // reads note the expected word and its mask; the monitor compares
  task automatic bus(logic w, logic [5:0] a, logic [31:0] d,
                     logic [31:0] m);
    @(posedge clk_i);
    if (!w) notes.push_back({m, d});
    adr  <= a;
    wdat <= d;
    wr   <= w;
    rd   <= !w;
    do @(posedge clk_i); while (wt_o !== 1'b0);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wt(int k);
    repeat (k) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (rd && wt_o === 1'b0 && notes.size() > 0) begin
      n = notes.pop_front();
      check("readdata", rdat & n[63:32], n[31:0]);
    end
    if (cyc == 30000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    void'($urandom(98));
    mref <= 16'($urandom);
    sref <= 16'($urandom);
    pot  <= 12'($urandom);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, 6'h00, 32'h10, 32'hFF);
    bus(0, 6'h3C, 32'h0, 32'hFFFF_FFFF);
    bus(1, 6'h24, 32'h0200_0010, 0);
    bus(1, 6'h20, 32'h0, 0);
    bus(1, 6'h00, 32'h1, 0);
    for (int v = 0; v < 8; v++) begin
      rsel <= 1'($urandom);
      bus(1, 6'h04, 32'(v * 17), 0);
      wt(3);
      check("code", 32'(code), (v == 0 || v == 3) ? 32'h0 :
            32'(regulator_pkg::ERR_CODE));
    end
    bus(1, 6'h04, 32'h0, 0);
    bus(1, 6'h34, 32'h1, 0);
    wt(3);
    check("irq set", 32'(irq), 32'h1);
    bus(1, 6'h30, 32'h7, 0);
    wt(3);
    check("irq clear", 32'(irq), 32'h0);
    bus(1, 6'h08, 32'h1B, 0);
    di <= 4'h1;
    zero <= 1'b1;
    bus(1, 6'h0C, 32'h1F4, 0);
    // let a sample tick take the zeroed feedback before the switch
    wt(25);
    check("manual", 32'(man), 32'h1);
    check("freq", 32'(freq), mref < 16'h10 ? 32'h10 :
          mref > 16'h200 ? 32'h200 : 32'(mref));
    di <= 4'h0;
    wt(3);
    check("auto", 32'(man), 32'h0);
    bus(0, 6'h0C, 32'h0, 32'h3FF);
    bus(1, 6'h00, 32'h5, 0);
    di <= 4'h1;
    bus(1, 6'h0C, 32'h1F4, 0);
    di <= 4'h0;
    wt(3);
    bus(0, 6'h0C, 32'h1F4, 32'h3FF);
    bus(1, 6'h08, 32'h0, 0);
    di <= 4'hF;
    zero <= 1'b0;
    bus(1, 6'h0C, 32'h7FF, 0);
    bus(0, 6'h0C, 32'h3E8, 32'h3FF);
    wt(3);
    check("no selector", 32'(man), 32'h0);
    wt(2000);
    check("direct", 32'(freq), 32'h200);
    bus(1, 6'h00, 32'h7, 0);
    // integrator must unwind what it wound up in the direct run, hence the long wait
    wt(8000);
    check("reverse", 32'(freq), 32'h10);
    bus(1, 6'h00, 32'h8, 0);
    mref <= 16'h0000;
    bus(0, 6'h0C, 32'h3E8, 32'h3FF);
    bus(1, 6'h00, 32'h0, 0);
    wt(25);
    bus(0, 6'h0C, 32'h0, 32'h3FF);
    check("disabled", 32'(freq), 32'(sref));
    check("display", 32'(disp),
          (32'({sref[10:0], 1'b0}) * 32'h3E8) >> 12);
    pot <= 12'hFFF;
    bus(1, 6'h04, 32'h33, 0);
    bus(1, 6'h00, 32'h1, 0);
    wt(200);
    check("pot setpoint", 32'(freq), 32'h200);
    wt(4);
    summarize();
  end
endmodule // testbench
